// [dv/flr_core_model.sv]
/*
  command core stand-in: every byte is a last command byte; a command
  with a result may first run a disk read execution phase of two bytes,
  one byte time apart, then offers one result byte until it is taken.
  assumes the port timing of flr_host_regs.
*/
`timescale 1ns/1ps
module flr_core_model (
  input  wire logic                   clk,     // 50 MHz clock
  input  wire logic                   rst,     // async reset
  input  wire logic                   noRes,   // command has no result phase
  input  wire logic                   doExec,  // command runs a disk read phase
  input  wire flr_pkg::flr_core_out_t coreOut, // from register bank
  output flr_pkg::flr_core_in_t       coreIn   // to register bank
);
  logic       pend_r; // result byte pending
  logic       ex_r;   // execution enter pulse, lands in the wait state
  logic       run_r;  // disk side producing read data
  logic [5:0] t_r;    // byte time divider
  logic [1:0] n_r;    // disk bytes produced so far
  logic       tick;   // end of one byte time
  logic       done;   // disk side finished
  assign tick = run_r && (t_r == 6'h3F);
  assign done = tick && (n_r == 2'h2);
  // pending from the command byte or disk end until the host reads it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) pend_r <= 1'b0;
    else if ((coreOut.hostByteValid && !noRes && !doExec) || done) pend_r <= 1'b1;
    else if (coreOut.resultTake) pend_r <= 1'b0;
  end
  // two disk bytes one byte time apart, then the end of execution
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ex_r  <= 1'b0;
      run_r <= 1'b0;
      t_r   <= 6'h00;
      n_r   <= 2'h0;
    end else begin
      ex_r <= coreOut.hostByteValid && !noRes && doExec;
      if (ex_r) begin
        run_r <= 1'b1;
        t_r   <= 6'h00;
        n_r   <= 2'h0;
      end else if (run_r) begin
        t_r <= t_r + 6'h01;
        if (tick) n_r <= n_r + 2'h1;
        if (done) run_r <= 1'b0;
      end
    end
  end
  // answers in the same cycle as the command byte
  always_comb begin
    coreIn               = '0;
    coreIn.seekA         = noRes;
    coreIn.seekB         = noRes;
    coreIn.execEnter     = ex_r;
    coreIn.execToHost    = 1'b1;
    coreIn.execDone      = done;
    coreIn.diskByteValid = tick && !done;
    coreIn.diskByte      = {6'h0C, n_r};
    coreIn.lastCmdByte   = coreOut.hostByteValid;
    coreIn.noResult      = noRes;
    coreIn.resultValid = pend_r;
    coreIn.resultByte  = 8'hA5;
    coreIn.resultLast  = 1'b1;
  end
endmodule // flr_core_model

// [dv/flr_host_regs_tb.sv]
/*
  self-checking bench for the host register bank: bus tasks, a reference
  model of the input register and rate logic, and one core stand-in.
  assumes the one-cycle strobe register port and a 50 MHz clock.
*/
`timescale 1ns/1ps
module flr_host_regs_tb;
  logic clk = 0, rst = 1, softReset = 0, busWr = 0, busRd = 0, noRes = 0;
  logic mediaChangeN = 1, forceMediaChange = 0, dmaGate = 0, dsrRateWr = 0, pr = 0, p;
  logic polledMode = 0, doExec = 0; // execution scenario controls
  logic [15:0] busAddr = 16'h0000, lf = 16'h5AB6; // lfsr seed 23222
  logic [7:0]  busWdata = 8'h00, busRdata, v;
  logic [1:0]  dsrRate = 2'h0, driveType = 2'h0;
  logic [2:0]  precompSel = 3'h0;
  logic [10:0] dataRateKbps;
  logic [16:0] precompDelayPs;
  logic        precompOff;
  flr_pkg::flr_mode_t     compatMode = flr_pkg::MODE_BASE;
  flr_pkg::flr_core_in_t  coreIn;
  flr_pkg::flr_core_out_t coreOut;
  int fails = 0, tests_run = 0, errs = 0;
  // clock, 20 ns period
  always #10 clk = ~clk;
  flr_host_regs dut (.clk(clk), .rst(rst), .softReset(softReset), .busAddr(busAddr),
    .busWdata(busWdata), .busWr(busWr), .busRd(busRd), .busRdata(busRdata),
    .compatMode(compatMode), .mediaChangeN(mediaChangeN), .forceMediaChange(forceMediaChange),
    .dmaGate(dmaGate), .polledMode(polledMode), .dsrRateWr(dsrRateWr), .dsrRate(dsrRate),
    .precompSel(precompSel), .driveType(driveType), .coreIn(coreIn), .coreOut(coreOut),
    .dataRateKbps(dataRateKbps), .precompDelayPs(precompDelayPs), .precompOff(precompOff));
  flr_core_model core (.clk(clk), .rst(rst), .noRes(noRes), .doExec(doExec), .coreOut(coreOut),
    .coreIn(coreIn));
  // counts overrun and underrun pulses
  always @(posedge clk) if (coreOut.xferError === 1'b1) errs <= errs + 1;
  // lfsr step
  function automatic logic [15:0] nx(input logic [15:0] l);
    return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
  endfunction
  // rate code to kbps
  function automatic int kb(input int c, input logic [1:0] dt);
    return c == 0 ? 500 : c == 1 ? (dt == 2'h2 ? 2000 : 300) : c == 2 ? 250 : 1000;
  endfunction
  // input register per layout
  function automatic logic [7:0] dirx(input int m, input logic [1:0] r, input logic c, g, q);
    if (m == 0) return {c, 7'h00};
    if (m == 1) return {c, 4'hF, r, (r == 2'h1 || r == 2'h2)};
    return {c, 3'h0, g, q, r};
  endfunction
  // counted compare
  task automatic chk(input logic [31:0] g, e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk) begin busAddr <= a; busWdata <= d; busWr <= 1'b1; end
    @(posedge clk) busWr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk) begin busAddr <= a; busRd <= 1'b1; end
    @(posedge clk) busRd <= 1'b0;
    #1 d = busRdata;
  endtask
  // bounded status poll; a timeout is a mismatch and ends the run
  task automatic poll(input logic [7:0] e);
    v = 8'h00;
    for (int k = 0; k < 100 && v !== e; k++) rd(16'h03F4, v);
    chk(v, e);
    if (v !== e) tally_and_finish;
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(16'h03F4, v); chk(v, 8'h80);
    rd(16'h0300, v); chk(v, 8'h00);
    for (int m = 0; m < 3; m++) for (int r = 0; r < 4; r++) begin
      lf = nx(lf);
      p = lf[0];
      @(posedge clk) begin compatMode <= flr_pkg::flr_mode_t'(m); mediaChangeN <= lf[1];
        dmaGate <= lf[2]; forceMediaChange <= lf[3]; driveType <= {lf[4], 1'b0}; end
      wr(16'h03F7, {5'h00, p & (m == 2), r[1:0]});
      if (m == 2) pr = p;
      rd(16'h03F7, v);
      chk(v, dirx(m, r[1:0], !lf[1] | lf[3], lf[2], pr));
      chk(dataRateKbps, kb(r, {lf[4], 1'b0}));
      chk(precompDelayPs, r == 1 && lf[4] ? 20800 : r == 3 ? 41670 : 125000);
      chk(precompOff, pr);
    end
    @(posedge clk) begin dsrRateWr <= 1'b1; dsrRate <= 2'h0; precompSel <= 3'h3; end
    @(posedge clk) dsrRateWr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(dataRateKbps, 500);
    chk(precompDelayPs, 0);
    @(posedge clk) begin softReset <= 1'b1; precompSel <= 3'h0; end
    @(posedge clk) softReset <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(dataRateKbps, 500);
    chk(precompOff, pr);
    @(posedge clk) noRes <= 1'b1;
    wr(16'h03F5, 8'h0F);
    repeat (3) @(posedge clk);
    rd(16'h03F4, v); chk(v, 8'h83);
    @(posedge clk) noRes <= 1'b0;
    wr(16'h03F5, 8'h08);
    poll(8'hD0);
    rd(16'h03F5, v); chk(v, 8'hA5);
    rd(16'h03F4, v); chk(v, 8'h80);
    // disk read execution: serviced in time, then left to overrun
    for (int q = 0; q < 2; q++) begin
      @(posedge clk) begin doExec <= 1'b1; polledMode <= (q == 0); end
      wr(16'h03F5, 8'h06);
      if (q == 1) repeat (140) @(posedge clk);
      for (int b = 0; b < 2 - q; b++) begin
        poll(q == 0 ? 8'hF0 : 8'hD0);
        rd(16'h03F5, v); chk(v, 8'h30 + b);
      end
      chk(coreOut.hostByte, 8'h06);
      poll(8'hD0);
      rd(16'h03F5, v); chk(v, 8'hA5);
    end
    chk(errs, 1);
    @(posedge clk) doExec <= 1'b0;
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(dataRateKbps, 250);
    chk(precompOff, 1'b0);
    rd(16'h03F7, v); chk(v[2:0], 3'h2);
    tally_and_finish;
  end
endmodule // flr_host_regs_tb

// [verilog/flr_host_regs.sv]
/*
  host side register bank of the floppy controller: main status, data
  port with optional fifo, input register in three layouts and the
  write-only rate config register, plus default precompensation.
  assumes a command core that answers each hostByteValid in the same
  cycle and a host using the plain one-cycle strobe register port.
*/
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
// How it works
// - default precomp: 20.8, 41.67, 125 ns
// - main status readable any time, no wait
// - seek bits show drive in seek
// - busy from first byte to result end
// - no result phase: busy clears immediately
// - polled bit set during execution phase in polled mode
// - direction bit tells read or write
// - request bit gates data port access
// - data port carries params, data, results
// - fifo disabled after any reset
// - fifo off at start, flushed on execution
// - overrun or underrun ends transfer
// - bit 7 is inverted media change
// - base mode input bits 0-6 zero
// - low density flag from rate
// - second mode shows rate, ones above
// - rate kept on soft, reset on hard
// - third mode: rate, precomp off, dma gate
// - rate config write sets rate
// - precomp off stored, no effect
// - latest rate write wins
// - rate codes map to kbps
module flr_host_regs #(
  parameter int FIFO_DEPTH = 16                     // fifo depth, power of two
) (
  input  wire logic                  clk,           // 50 MHz clock
  input  wire logic                  rst,           // hardware reset, async high
  input  wire logic                  softReset,     // software reset pulse
  input  wire logic [15:0]           busAddr,       // i/o address
  input  wire logic [7:0]            busWdata,      // write data
  input  wire logic                  busWr,         // write strobe
  input  wire logic                  busRd,         // read strobe
  output logic [7:0]                 busRdata,      // read data, cycle after
  input  wire flr_pkg::flr_mode_t    compatMode,    // register layout select
  input  wire logic                  mediaChangeN,  // media change pin, low active
  input  wire logic                  forceMediaChange, // forced media change
  input  wire logic                  dmaGate,       // dma gate from output reg
  input  wire logic                  polledMode,    // polled transfer selected
  input  wire logic                  dsrRateWr,     // rate select reg written
  input  wire logic [1:0]            dsrRate,       // rate from rate select reg
  input  wire logic [2:0]            precompSel,    // precomp code
  input  wire logic [1:0]            driveType,     // drive type code
  input  wire flr_pkg::flr_core_in_t coreIn,        // from command core
  output flr_pkg::flr_core_out_t     coreOut,       // to command core
  output logic [10:0]                dataRateKbps,  // active data rate
  output logic [16:0]                precompDelayPs,// write precomp delay
  output logic                       precompOff     // stored precomp off bit
);
  localparam int AW = $clog2(FIFO_DEPTH);           // pointer width
  localparam int CW = $clog2(FIFO_DEPTH + 1);       // count width
  localparam logic [CW-1:0] DEPTH_C = CW'(FIFO_DEPTH);

  typedef enum logic [2:0] {S_IDLE, S_PARAM, S_WAIT, S_EXEC, S_RESULT} flr_state_t;

  flr_state_t        state_r;                       // command phase
  logic [7:0]        mem [FIFO_DEPTH];              // fifo storage
  logic [AW-1:0]     wp_r, rp_r;                    // fifo pointers
  logic [CW-1:0]     cnt_r;                         // fifo fill
  logic              fifoEn_r;                      // fifo enabled by configure
  logic [3:0]        thresh_r;                      // threshold code
  logic              toHost_r;                      // execution direction
  logic              stop_r;                        // transfer ended by error
  logic              endSeen_r;                     // core finished disk side
  logic [1:0]        rate_r;                        // rate select code
  logic              hostByteValid_r;               // command byte strobe
  logic              hostByteFirst_r;               // opcode marker
  logic [7:0]        hostByte_r;                    // command byte
  logic [7:0]        rdata_r;                       // read data register
  logic [10:0]       kbps_r;                        // rate in kbps
  logic [16:0]       precompPs_r;                   // precomp delay

  logic              wrData, rdData, wrCfg, rdMsr, rdDir; // decoded strobes
  logic [CW-1:0]     depthEff, thrEff;              // effective depth, threshold
  logic              host_transfer_request, transfer_direction, busy, nonDma;        // status bits
  logic [7:0]        main_status, dirVal;                   // register read values
  logic              push, pop, flush, xferErr;     // fifo events
  logic              mediaChanged;                  // bit 7 of input register

  // address decode of the strobes
  assign wrData = busWr && (busAddr == flr_pkg::DATA_PORT_ADDR);
  assign rdData = busRd && (busAddr == flr_pkg::DATA_PORT_ADDR);
  assign wrCfg  = busWr && (busAddr == flr_pkg::RATE_CONFIG_ADDR);
  assign rdMsr  = busRd && (busAddr == flr_pkg::MAIN_STATUS_ADDR);
  assign rdDir  = busRd && (busAddr == flr_pkg::INPUT_STATUS_ADDR);

  // fifo disabled acts as a one byte buffer handshaken byte by byte
  assign depthEff = fifoEn_r ? DEPTH_C : CW'(1);
  assign thrEff   = fifoEn_r ? (CW'(thresh_r) + CW'(1)) : CW'(1);

  // request, direction, busy and polled status
  always_comb begin
    host_transfer_request = 1'b0;
    transfer_direction = 1'b0;
    case (state_r)
      S_IDLE:   host_transfer_request = 1'b1;
      S_PARAM:  host_transfer_request = !hostByteValid_r;
      S_WAIT:   host_transfer_request = 1'b0;
      S_EXEC: begin
        transfer_direction = toHost_r;
        if (toHost_r) begin
          // leftover bytes below threshold drain once the disk side ends
          host_transfer_request = (cnt_r != '0) && (cnt_r >= thrEff || stop_r || endSeen_r);
        end else begin
          host_transfer_request = !stop_r && !endSeen_r && ((depthEff - cnt_r) >= thrEff);
        end
      end
      S_RESULT: begin
        transfer_direction = 1'b1;
        host_transfer_request = coreIn.resultValid;
      end
      default: begin
        host_transfer_request = 1'b0;
        transfer_direction = 1'b0;
      end
    endcase
  end
  assign busy   = (state_r != S_IDLE);
  assign nonDma = polledMode && (state_r == S_EXEC);
  // seek bits pass straight from the core so they are current on any read
  always_comb begin
    main_status = 8'h00;
    main_status[flr_pkg::MSR_SEEK_A] = coreIn.seekA;
    main_status[flr_pkg::MSR_SEEK_B] = coreIn.seekB;
    main_status[flr_pkg::MSR_BUSY]   = busy;
    main_status[flr_pkg::MSR_POLLED] = nonDma;
    main_status[flr_pkg::MSR_DIR]    = transfer_direction;
    main_status[flr_pkg::MSR_RQM]    = host_transfer_request;
  end

  // fifo events; host accesses while rqm is low are ignored
  assign push = (state_r == S_EXEC) && !stop_r &&
                (toHost_r ? (coreIn.diskByteValid && cnt_r < depthEff)
                          : (wrData && host_transfer_request));
  assign pop  = (state_r == S_EXEC) &&
                (toHost_r ? (rdData && host_transfer_request)
                          : (coreIn.diskByteTake && cnt_r != '0));
  assign flush = softReset || (state_r == S_WAIT && coreIn.execEnter);
  // overrun on a full fifo in reads, underrun on an empty one in writes
  assign xferErr = (state_r == S_EXEC) && !stop_r &&
                   (toHost_r ? (coreIn.diskByteValid && cnt_r >= depthEff)
                             : (coreIn.diskByteTake && cnt_r == '0));

  // fifo storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= toHost_r ? coreIn.diskByte : busWdata;
    end
  end

  // fifo pointers and count, flush has priority
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else if (flush) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + AW'(1);
      if (pop)  rp_r <= rp_r + AW'(1);
      if (push && !pop) cnt_r <= cnt_r + CW'(1);
      else if (pop && !push) cnt_r <= cnt_r - CW'(1);
    end
  end

  // fifo setup: off after either reset, loaded by configure
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fifoEn_r <= flr_pkg::FIFO_EN_RESET;
      thresh_r <= flr_pkg::THRESH_RESET;
    end else if (softReset) begin
      fifoEn_r <= flr_pkg::FIFO_EN_RESET;
      thresh_r <= flr_pkg::THRESH_RESET;
    end else if (coreIn.fifoCfgValid) begin
      fifoEn_r <= coreIn.fifoCfgEnable;
      thresh_r <= coreIn.fifoCfgThresh;
    end
  end

  // command phase sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= S_IDLE;
    end else if (softReset) begin
      state_r <= S_IDLE;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (wrData) state_r <= S_PARAM;
        end
        S_PARAM: begin
          if (hostByteValid_r && coreIn.lastCmdByte) begin
            state_r <= coreIn.noResult ? S_IDLE : S_WAIT;
          end
        end
        S_WAIT: begin
          if (coreIn.execEnter) state_r <= S_EXEC;
          else if (coreIn.resultValid) state_r <= S_RESULT;
        end
        S_EXEC: begin
          // reads end only after the host drained the fifo
          if (endSeen_r && (!toHost_r || cnt_r == '0)) state_r <= S_RESULT;
        end
        S_RESULT: begin
          if (rdData && coreIn.resultValid && coreIn.resultLast) state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // execution direction, error stop and disk side end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      toHost_r  <= 1'b0;
      stop_r    <= 1'b0;
      endSeen_r <= 1'b0;
    end else if (softReset || state_r != S_EXEC) begin
      if (state_r == S_WAIT && coreIn.execEnter) toHost_r <= coreIn.execToHost;
      stop_r    <= 1'b0;
      endSeen_r <= 1'b0;
    end else begin
      if (xferErr) stop_r <= 1'b1;
      if (coreIn.execDone) endSeen_r <= 1'b1;
    end
  end

  // command bytes forwarded to the core, one handshake each
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hostByteValid_r <= 1'b0;
      hostByteFirst_r <= 1'b0;
      hostByte_r      <= 8'h00;
    end else begin
      hostByteValid_r <= !softReset && wrData &&
                         (state_r == S_IDLE || (state_r == S_PARAM && host_transfer_request));
      hostByteFirst_r <= (state_r == S_IDLE);
      if (wrData) hostByte_r <= busWdata;
    end
  end

  // rate code: latest write wins, soft reset leaves it alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rate_r <= flr_pkg::RATE_RESET;
    end else if (wrCfg) begin
      rate_r <= busWdata[1:0];
    end else if (dsrRateWr) begin
      rate_r <= dsrRate;
    end
  end

  // precomp off is stored only through the third layout
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      precompOff <= flr_pkg::PRECOMP_OFF_RESET;
    end else if (wrCfg && compatMode == flr_pkg::MODE_THIRD) begin
      precompOff <= busWdata[2];
    end
  end

  // rate in kbps and default precompensation delay
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      kbps_r      <= flr_pkg::KBPS_250;
      precompPs_r <= flr_pkg::PRECOMP_PS_SLOW;
    end else begin
      case (rate_r)
        flr_pkg::RATE_500K: kbps_r <= flr_pkg::KBPS_500;
        flr_pkg::RATE_300K: kbps_r <= (driveType == flr_pkg::DRIVE_TAPE2M) ?
                                      flr_pkg::KBPS_2000 : flr_pkg::KBPS_300;
        flr_pkg::RATE_250K: kbps_r <= flr_pkg::KBPS_250;
        default:            kbps_r <= flr_pkg::KBPS_1000;
      endcase
      if (precompSel != flr_pkg::PRECOMP_DEFAULT) precompPs_r <= 17'h00000;
      else if (kbps_r == flr_pkg::KBPS_2000) precompPs_r <= flr_pkg::PRECOMP_PS_2M;
      else if (kbps_r == flr_pkg::KBPS_1000) precompPs_r <= flr_pkg::PRECOMP_PS_1M;
      else precompPs_r <= flr_pkg::PRECOMP_PS_SLOW;
    end
  end

  // input register in the layout chosen by the mode input
  assign mediaChanged = !mediaChangeN || forceMediaChange;
  always_comb begin
    case (compatMode)
      flr_pkg::MODE_SECOND: dirVal = {mediaChanged, 4'hF, rate_r,
                                      (rate_r == flr_pkg::RATE_300K ||
                                       rate_r == flr_pkg::RATE_250K)};
      flr_pkg::MODE_THIRD:  dirVal = {mediaChanged, 3'h0, dmaGate,
                                      precompOff, rate_r};
      default:              dirVal = {mediaChanged, 7'h00};
    endcase
  end

  // read data stand for exactly one cycle, unmapped reads give zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (rdMsr) begin
      rdata_r <= main_status;
    end else if (rdDir) begin
      rdata_r <= dirVal;
    end else if (rdData && host_transfer_request && state_r == S_EXEC) begin
      rdata_r <= mem[rp_r];
    end else if (rdData && host_transfer_request && state_r == S_RESULT) begin
      rdata_r <= coreIn.resultByte;
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign busRdata               = rdata_r;
  assign dataRateKbps           = kbps_r;
  assign precompDelayPs         = precompPs_r;
  assign coreOut.hostByteValid  = hostByteValid_r;
  assign coreOut.hostByteFirst  = hostByteFirst_r;
  assign coreOut.hostByte       = hostByte_r;
  assign coreOut.diskWrByte     = mem[rp_r];
  assign coreOut.resultTake     = rdData && (state_r == S_RESULT) && coreIn.resultValid;
  assign coreOut.xferError      = xferErr;

  // checks on the status and data behaviour
  sequence s_firstByte;
    state_r == S_IDLE && wrData && !softReset;
  endsequence
  sequence s_paramsNoResult;
    state_r == S_PARAM && hostByteValid_r && coreIn.lastCmdByte && coreIn.noResult && !softReset;
  endsequence

  a_busy_first_byte: assert property (@(posedge clk) disable iff (rst)
    s_firstByte |=> busy && !host_transfer_request) else $error("busy not set after first byte");
  a_no_result_idle: assert property (@(posedge clk) disable iff (rst)
    s_paramsNoResult |=> !busy && host_transfer_request) else $error("busy kept without result phase");
  a_polled_exec: assert property (@(posedge clk) disable iff (rst)
    nonDma |-> state_r == S_EXEC && polledMode) else $error("polled bit outside execution");
  a_msr_read_value: assert property (@(posedge clk) disable iff (rst)
    rdMsr && !softReset |=> busRdata == $past(main_status)) else $error("status read mismatch");
  a_read_one_cycle: assert property (@(posedge clk) disable iff (rst)
    !$past(busRd) |-> busRdata == 8'h00) else $error("read data outside its cycle");
  a_fifo_off_reset: assert property (@(posedge clk) disable iff (rst)
    softReset |=> !fifoEn_r ##1 (!fifoEn_r || $past(coreIn.fifoCfgValid)))
    else $error("fifo enabled after soft reset");
  a_flush_exec: assert property (@(posedge clk) disable iff (rst)
    state_r == S_WAIT && coreIn.execEnter && !softReset |=> state_r == S_EXEC && cnt_r == '0)
    else $error("fifo not flushed on execution");
  a_error_stops: assert property (@(posedge clk) disable iff (rst)
    xferErr && !softReset |=> stop_r && !push) else $error("transfer not stopped on error");
  a_rate_soft_keep: assert property (@(posedge clk) disable iff (rst)
    softReset && !wrCfg && !dsrRateWr |=> rate_r == $past(rate_r)) else $error("rate lost");
  a_cfg_rate_wins: assert property (@(posedge clk) disable iff (rst)
    wrCfg |=> rate_r == $past(busWdata[1:0]) ##1 (kbps_r == flr_pkg::KBPS_500) ==
    ($past(rate_r) == flr_pkg::RATE_500K)) else $error("rate config write ignored");
  a_dir_base_zero: assert property (@(posedge clk) disable iff (rst)
    rdDir && compatMode == flr_pkg::MODE_BASE |=> busRdata[6:0] == 7'h00 &&
    busRdata[7] == $past(mediaChanged)) else $error("base input layout wrong");
  a_dir_second: assert property (@(posedge clk) disable iff (rst)
    rdDir && compatMode == flr_pkg::MODE_SECOND |=> busRdata[6:3] == 4'hF &&
    busRdata[0] == ($past(rate_r) == flr_pkg::RATE_300K || $past(rate_r) == flr_pkg::RATE_250K))
    else $error("second input layout wrong");
  a_rqm_result_dir: assert property (@(posedge clk) disable iff (rst)
    state_r == S_RESULT |-> transfer_direction && (host_transfer_request == coreIn.resultValid)) else $error("result direction wrong");
endmodule // flr_host_regs

// [verilog/flr_pkg.sv]
/*
  shared constants and carriers for the floppy host register bank:
  i/o addresses, reset values, rate codes, precompensation delays,
  compatibility modes and the structs exchanged with the command core.
  assumes an 8-bit i/o port with 16-bit addresses and a 50 MHz clock.
*/
package flr_pkg;
  // i/o addresses as decoded on the plain register port
  localparam logic [15:0] MAIN_STATUS_ADDR  = 16'h03F4; // status, read only
  localparam logic [15:0] DATA_PORT_ADDR    = 16'h03F5; // data register
  localparam logic [15:0] INPUT_STATUS_ADDR = 16'h03F7; // input register, read
  localparam logic [15:0] RATE_CONFIG_ADDR  = 16'h03F7; // rate config, write
  // rate select codes and hardware reset value
  localparam logic [1:0]  RATE_500K   = 2'h0;
  localparam logic [1:0]  RATE_300K   = 2'h1;
  localparam logic [1:0]  RATE_250K   = 2'h2;
  localparam logic [1:0]  RATE_1M     = 2'h3;
  localparam logic [1:0]  RATE_RESET  = RATE_250K;
  // rates in kbps, 2000 only for the 2 Mbps drive type
  localparam logic [10:0] KBPS_500    = 11'h1F4;
  localparam logic [10:0] KBPS_300    = 11'h12C;
  localparam logic [10:0] KBPS_250    = 11'h0FA;
  localparam logic [10:0] KBPS_1000   = 11'h3E8;
  localparam logic [10:0] KBPS_2000   = 11'h7D0;
  localparam logic [1:0]  DRIVE_TAPE2M = 2'h2;   // drive type with 2 Mbps code
  // default precompensation code and delays in picoseconds
  localparam logic [2:0]  PRECOMP_DEFAULT  = 3'h0;
  localparam logic [16:0] PRECOMP_PS_2M    = 17'h05140; // 20.8 ns
  localparam logic [16:0] PRECOMP_PS_1M    = 17'h0A2C6; // 41.67 ns
  localparam logic [16:0] PRECOMP_PS_SLOW  = 17'h1E848; // 125 ns
  // status register field positions
  localparam int MSR_SEEK_A = 0;
  localparam int MSR_SEEK_B = 1;
  localparam int MSR_BUSY   = 4;
  localparam int MSR_POLLED = 5;
  localparam int MSR_DIR    = 6;
  localparam int MSR_RQM    = 7;
  // reset values of configure state
  localparam logic       FIFO_EN_RESET = 1'b0;
  localparam logic [3:0] THRESH_RESET  = 4'h0;
  localparam logic       PRECOMP_OFF_RESET = 1'b0;

  // compatibility layout of the input and rate config registers
  typedef enum logic [1:0] {MODE_BASE, MODE_SECOND, MODE_THIRD} flr_mode_t;

  // command core to register bank
  typedef struct packed {
    logic       seekA;         // drive a in seek portion
    logic       seekB;         // drive b in seek portion
    logic       lastCmdByte;   // byte on hostByte is the last command byte
    logic       noResult;      // with lastCmdByte: command has no result phase
    logic       execEnter;     // entering execution phase
    logic       execToHost;    // with execEnter: disk data flows to host
    logic       execDone;      // disk side finished its transfer
    logic       diskByteValid; // disk read byte pushed into fifo
    logic [7:0] diskByte;      // disk read byte
    logic       diskByteTake;  // disk write side takes fifo head
    logic       resultValid;   // a result byte is offered
    logic [7:0] resultByte;    // offered result byte
    logic       resultLast;    // offered result byte is the last one
    logic       fifoCfgValid;  // configure command loads fifo setup
    logic       fifoCfgEnable; // fifo enable from configure
    logic [3:0] fifoCfgThresh; // threshold from configure, n means n+1 bytes
  } flr_core_in_t;

  // register bank to command core
  typedef struct packed {
    logic       hostByteValid; // pulse: command byte written by host
    logic       hostByteFirst; // with hostByteValid: opcode byte
    logic [7:0] hostByte;      // written command byte
    logic [7:0] diskWrByte;    // fifo head for disk writes
    logic       resultTake;    // pulse: host read the offered result byte
    logic       xferError;     // pulse: overrun or underrun seen
  } flr_core_out_t;
endpackage
